// ### pkg/mtp_host_pkg.sv
// Package with command codes, pin carriers, timing counts and states of the memory programmer.
package mtp_host_pkg;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned ADDR_W = 18;
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_ERASE_CHECK = 8'hA0;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_PROGRAM_CHECK = 8'hC0;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] ERASED_VALUE = 8'hFF;
  localparam int unsigned WRITE_LOW_NS = 50;
  localparam int unsigned WRITE_HIGH_NS = 20;
  localparam int unsigned PROGRAM_PULSE_US = 10;
  localparam int unsigned ERASE_PULSE_MS = 100;
  localparam int unsigned WRITE_TO_READ_US = 6;
  localparam int unsigned SUPPLY_SETUP_US = 1;
  localparam int unsigned READ_ACCESS_NS = 150;
  localparam int unsigned WRITE_LOW_CYC = (WRITE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WRITE_HIGH_CYC = (WRITE_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PROGRAM_PULSE_CYC = PROGRAM_PULSE_US * CLK_MHZ;
  localparam int unsigned ERASE_PULSE_CYC = ERASE_PULSE_MS * 1000 * CLK_MHZ;
  localparam int unsigned WRITE_TO_READ_CYC = WRITE_TO_READ_US * CLK_MHZ;
  localparam int unsigned SUPPLY_SETUP_CYC = SUPPLY_SETUP_US * CLK_MHZ;
  localparam int unsigned READ_ACCESS_CYC = (READ_ACCESS_NS * CLK_MHZ + 999) / 1000 + 1;
  localparam int unsigned CNT_W = 24;

  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_ERASE = 3'h1,
    OP_ERASE_CHECK = 3'h2,
    OP_PROGRAM = 3'h3,
    OP_PROGRAM_CHECK = 3'h4,
    OP_RESET = 3'h5
  } op_t;

  typedef struct packed {
    op_t op;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } request_t;

  typedef struct packed {
    logic select_n;
    logic read_n;
    logic write_n;
    logic supply_high;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data_out;
    logic data_oe;
  } mem_pins_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_SUPPLY = 4'h1,
    ST_CMD1 = 4'h3,
    ST_CMD2 = 4'h2,
    ST_RECOVER = 4'h6,
    ST_READ = 4'h7,
    ST_DONE = 4'h5,
    ST_PULSE = 4'h4
  } state_t;
endpackage

// ### verilog/mtp_write_cycle.sv
// One write-strobe cycle on the memory pins with minimum low and high times.
`timescale 1ns/100ps
`default_nettype none
module mtp_write_cycle (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic start,
  output logic busy,
  output logic strobe_n,
  output logic done
);
  import mtp_host_pkg::*;
  logic [3:0] count;
  logic phase_low;
  logic phase_high;

  // The strobe is low for at least the minimum width, then high for the minimum gap.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 4'h0;
      phase_low <= 1'b0;
      phase_high <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start && !phase_low && !phase_high) begin
        phase_low <= 1'b1;
        count <= 4'(WRITE_LOW_CYC);
      end else if (phase_low) begin
        if (count <= 4'h1) begin
          phase_low <= 1'b0;
          phase_high <= 1'b1;
          count <= 4'(WRITE_HIGH_CYC);
        end else begin
          count <= count - 4'h1;
        end
      end else if (phase_high) begin
        if (count <= 4'h1) begin
          phase_high <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - 4'h1;
        end
      end
    end
  end

  assign strobe_n = ~phase_low;
  assign busy = phase_low | phase_high;
endmodule
`default_nettype wire

// ### verilog/mtp_host.sv
// Programmer that drives the command port of a byte-wide reprogrammable memory.
`timescale 1ns/100ps
`default_nettype none
module mtp_host #(
  parameter int unsigned ERASE_WAIT_CYC = mtp_host_pkg::ERASE_PULSE_CYC
) (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic CLK_EN,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire mtp_host_pkg::request_t REQ,
  output logic RSP_VALID,
  output logic [7:0] RSP_DATA,
  output logic RSP_ERASED,
  output mtp_host_pkg::mem_pins_t PINS,
  input wire logic [7:0] MEM_DATA_IN
);
  import mtp_host_pkg::*;

  state_t state;
  request_t cur;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] pulse_wait;
  logic wr_start;
  logic wr_busy;
  logic wr_strobe_n;
  logic wr_done;
  logic [7:0] first_code;
  logic [7:0] second_data;
  logic second_is_write;
  logic is_check;

  // Decode of each operation into its bus cycles.
  always_comb begin
    first_code = CMD_READ;
    second_data = 8'h00;
    second_is_write = 1'b0;
    is_check = 1'b0;
    unique case (cur.op)
      OP_READ: begin
        first_code = CMD_READ;
      end
      OP_ERASE: begin
        first_code = CMD_ERASE;
        second_data = CMD_ERASE;
        second_is_write = 1'b1;
      end
      OP_ERASE_CHECK: begin
        first_code = CMD_ERASE_CHECK;
        is_check = 1'b1;
      end
      OP_PROGRAM: begin
        first_code = CMD_PROGRAM;
        second_data = cur.data;
        second_is_write = 1'b1;
      end
      OP_PROGRAM_CHECK: begin
        first_code = CMD_PROGRAM_CHECK;
        is_check = 1'b1;
      end
      OP_RESET: begin
        first_code = CMD_RESET;
        second_data = CMD_RESET;
        second_is_write = 1'b1;
      end
      default: begin
        first_code = CMD_READ;
      end
    endcase
  end

  mtp_write_cycle u_write (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .ce(CLK_EN),
    .start(wr_start),
    .busy(wr_busy),
    .strobe_n(wr_strobe_n),
    .done(wr_done)
  );

  assign wr_start = (state == ST_CMD1 || state == ST_CMD2) && !wr_busy && !wr_done && count == '0;
  assign REQ_READY = (state == ST_IDLE) && (pulse_wait == '0);

  // Sequencer of supply, command cycles, recovery and read.
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= ST_IDLE;
      cur <= '0;
      count <= '0;
    end else if (CLK_EN) begin
      if (count != '0) begin
        count <= count - 1'b1;
      end
      unique case (state)
        ST_IDLE: begin
          if (REQ_VALID && REQ_READY) begin
            cur <= REQ;
            state <= ST_SUPPLY;
            count <= CNT_W'(SUPPLY_SETUP_CYC);
          end
        end
        ST_SUPPLY: begin
          if (count <= CNT_W'(1)) begin
            state <= ST_CMD1;
            count <= '0;
          end
        end
        ST_CMD1: begin
          if (wr_done) begin
            if (second_is_write) begin
              state <= ST_CMD2;
            end else if (is_check) begin
              state <= ST_RECOVER;
              count <= CNT_W'(WRITE_TO_READ_CYC);
            end else begin
              state <= ST_DONE;
            end
          end
        end
        ST_CMD2: begin
          if (wr_done) begin
            state <= ST_DONE;
          end
        end
        ST_RECOVER: begin
          if (count <= CNT_W'(1)) begin
            state <= ST_READ;
            count <= CNT_W'(READ_ACCESS_CYC);
          end
        end
        ST_READ: begin
          if (count <= CNT_W'(1)) begin
            state <= ST_DONE;
            count <= '0;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // The memory times its own pulse, so only the minimum is enforced before the next command.
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pulse_wait <= '0;
    end else if (CLK_EN) begin
      if (state == ST_CMD2 && wr_done && cur.op == OP_ERASE) begin
        pulse_wait <= CNT_W'(ERASE_WAIT_CYC);
      end else if (state == ST_CMD2 && wr_done && cur.op == OP_PROGRAM) begin
        pulse_wait <= CNT_W'(PROGRAM_PULSE_CYC);
      end else if (pulse_wait != '0) begin
        pulse_wait <= pulse_wait - 1'b1;
      end
    end
  end

  // Pin drive: address stays stable over the whole write, data stays until after the rising edge.
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PINS <= '{select_n: 1'b1, read_n: 1'b1, write_n: 1'b1, supply_high: 1'b0,
                addr: '0, data_out: 8'h00, data_oe: 1'b0};
    end else if (CLK_EN) begin
      // Taking a request keeps the supply up, so it never dips for a cycle after a pulse wait.
      PINS.supply_high <= (state != ST_IDLE && state != ST_DONE) || pulse_wait != '0 ||
                          (REQ_VALID && REQ_READY);
      PINS.select_n <= !(state == ST_CMD1 || state == ST_CMD2 || state == ST_RECOVER ||
                         state == ST_READ);
      PINS.write_n <= wr_strobe_n;
      PINS.read_n <= !(state == ST_READ);
      PINS.data_oe <= (state == ST_CMD1 || state == ST_CMD2);
      if (state == ST_SUPPLY || (state == ST_CMD1 && wr_done)) begin
        PINS.addr <= cur.addr;
      end
      if (state == ST_SUPPLY) begin
        PINS.data_out <= first_code;
      end else if (state == ST_CMD1 && wr_done) begin
        PINS.data_out <= second_data;
      end
    end
  end

  // Answer: read data sampled at the end of the read, with the erased flag.
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RSP_VALID <= 1'b0;
      RSP_DATA <= 8'h00;
      RSP_ERASED <= 1'b0;
    end else if (CLK_EN) begin
      RSP_VALID <= (state == ST_DONE);
      if (state == ST_READ && count <= CNT_W'(1)) begin
        RSP_DATA <= MEM_DATA_IN;
        RSP_ERASED <= (MEM_DATA_IN == ERASED_VALUE);
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/mtp_host_props.sv
// Checker of pin timing and answers of the memory programmer.
`timescale 1ns/100ps
`default_nettype none
module mtp_host_props (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic CLK_EN,
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire mtp_host_pkg::request_t REQ,
  input wire logic RSP_VALID,
  input wire logic [7:0] RSP_DATA,
  input wire logic RSP_ERASED,
  input wire mtp_host_pkg::mem_pins_t PINS,
  input wire logic [7:0] MEM_DATA_IN
);
  import mtp_host_pkg::*;
  logic [15:0] sup;
  logic [15:0] rec;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  // Counts saturate so that a long idle spell cannot wrap into a false failure.
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sup <= 16'h0;
      rec <= 16'h0;
    end else begin
      sup <= !PINS.supply_high ? 16'h0 : sup + {15'h0, sup != 16'hFFFF};
      rec <= !PINS.write_n ? 16'h0 : rec + {15'h0, rec != 16'hFFFF};
    end
  end
  a_supply_on_write: assert property (!PINS.write_n |-> PINS.supply_high)
    else $error("strobe low without supply");
  a_supply_setup: assert property ($fell(PINS.select_n) |-> sup >= SUPPLY_SETUP_CYC)
    else $error("select too soon after supply");
  a_strobe_low: assert property ($fell(PINS.write_n) |-> !PINS.write_n [*3])
    else $error("strobe low too short");
  a_addr_hold: assert property (!PINS.write_n && !$past(PINS.write_n)
    |-> $stable(PINS.addr) && !PINS.select_n) else $error("address moved in strobe");
  a_data_hold: assert property ($rose(PINS.write_n)
    |-> PINS.data_oe && $stable(PINS.data_out)) else $error("data moved at strobe rise");
  a_read_wait: assert property ($fell(PINS.read_n) |-> rec >= WRITE_TO_READ_CYC)
    else $error("read strobe too soon");
  a_no_fight: assert property (!PINS.read_n |-> !PINS.data_oe && PINS.write_n)
    else $error("driving data during read");
  a_erased_flag: assert property (RSP_VALID |-> RSP_ERASED == (RSP_DATA == ERASED_VALUE))
    else $error("erased flag wrong");
  a_supply_hold: assert property ($fell(PINS.supply_high) |-> REQ_READY)
    else $error("supply dropped during pulse wait");
endmodule
`default_nettype wire

// ### bench/mtp_mem_model.sv
// Behavioural model of the memory's command port.
`timescale 1ns/100ps
`default_nettype none
module mtp_mem_model (
  input wire mtp_host_pkg::mem_pins_t pins,
  output logic [7:0] q
);
  import mtp_host_pkg::*;
  logic [7:0] mem [int];
  logic [7:0] cmd = 8'h00;
  logic [7:0] last = 8'h00;
  int wa;
  int pa;
  int ca;
  function automatic logic [7:0] rd(input int a);
    return mem.exists(a) ? mem[a] : ERASED_VALUE;
  endfunction
  always @(negedge pins.write_n) wa = int'(pins.addr);
  // A pulse simply ends at the next strobe rise, so no timer is kept.
  always @(posedge pins.write_n) begin
    if (!pins.select_n && pins.supply_high) begin
      if (cmd == CMD_PROGRAM) begin
        mem[wa] = rd(wa) & pins.data_out;
        pa = wa;
        cmd = 8'h01;
      end else if (cmd == CMD_ERASE && pins.data_out == CMD_ERASE) begin
        mem.delete();
        cmd = 8'h01;
      end else if (cmd == CMD_RESET && pins.data_out == CMD_RESET) begin
        cmd = CMD_READ;
      end else begin
        cmd = pins.data_out;
        ca = wa;
      end
    end
  end
  // Undriven lines show the inverse of the last byte, never a stale copy.
  always @* begin
    if (!pins.select_n && !pins.read_n) begin
      if (cmd == CMD_ERASE_CHECK) begin
        q = rd(ca);
      end else if (cmd == CMD_PROGRAM_CHECK) begin
        q = rd(pa);
      end else begin
        q = rd(pins.addr);
      end
      last = q;
    end else begin
      q = ~last;
    end
  end
endmodule
`default_nettype wire

// ### bench/byte_memory_command_port_bench.sv
// Self-checking bench of the memory programmer.
`timescale 1ns/100ps
`default_nettype none
module byte_memory_command_port_bench;
  import mtp_host_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  logic req_valid = 1'b0;
  logic req_ready;
  request_t req = '0;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic rsp_erased;
  mem_pins_t pins;
  logic [7:0] mem_q;
  int err_count = 0;
  int compares = 0;
  int seed = 32'h94EE04FD;
  int refm [int];
  int last_pa;
  always #10 clk = ~clk;
  always @(posedge clk) clk_en <= ($random(seed) & 32'h7) != 32'h0;
  mtp_host #(.ERASE_WAIT_CYC(200)) dut (.REF_CLK(clk), .ARST_N(arst_n), .CLK_EN(clk_en),
    .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ(req), .RSP_VALID(rsp_valid),
    .RSP_DATA(rsp_data), .RSP_ERASED(rsp_erased), .PINS(pins), .MEM_DATA_IN(mem_q));
  mtp_mem_model u_mem (.pins(pins), .q(mem_q));
  function automatic logic [7:0] rdv(input int a);
    return refm.exists(a) ? 8'(refm[a]) : ERASED_VALUE;
  endfunction
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic do_op(input op_t op, input logic [17:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req <= '{op, a, d};
    @(posedge clk);
    while (!(req_ready === 1'b1 && clk_en === 1'b1) && n < 30000) begin
      @(posedge clk);
      n++;
    end
    req_valid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 60000);
    chk1("response", 1'b1, rsp_valid);
    if (op == OP_ERASE)
      refm.delete();
    if (op == OP_PROGRAM) begin
      refm[int'(a)] = rdv(int'(a)) & d;
      last_pa = int'(a);
    end
  endtask
  initial begin
    logic [17:0] a;
    logic [7:0] d;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    do_op(OP_ERASE, 18'($random(seed)), 8'($random(seed)));
    chk1("ready after erase", 1'b0, req_ready);
    for (int i = 0; i < 6; i++) begin
      a = 18'($random(seed));
      d = 8'($random(seed));
      do_op(OP_PROGRAM, a, d);
      chk1("ready after program", 1'b0, req_ready);
      do_op(OP_PROGRAM_CHECK, 18'($random(seed)), d);
      chk8("program check", rdv(last_pa), rsp_data);
      do_op(OP_ERASE_CHECK, a, d);
      chk8("erase check", rdv(int'(a)), rsp_data);
      chk1("erased flag", rdv(int'(a)) == ERASED_VALUE, rsp_erased);
    end
    do_op(OP_RESET, a, d);
    chk8("mode after reset", CMD_READ, u_mem.cmd);
    do_op(OP_ERASE, a, d);
    do_op(OP_READ, a, d);
    chk8("mode after read", CMD_READ, u_mem.cmd);
    do_op(OP_ERASE_CHECK, a, d);
    chk8("check after erase", ERASED_VALUE, rsp_data);
    chk1("erased after erase", 1'b1, rsp_erased);
    complete_run();
  end
  initial begin
    #800000;
    err_count++;
    complete_run();
  end
endmodule
bind mtp_host mtp_host_props u_props (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .CLK_EN(CLK_EN),
  .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ(REQ), .RSP_VALID(RSP_VALID),
  .RSP_DATA(RSP_DATA), .RSP_ERASED(RSP_ERASED), .PINS(PINS), .MEM_DATA_IN(MEM_DATA_IN));
`default_nettype wire
